// >>> rtl/move_branch_or_exec.sv
// Execution unit for OR-immediate, special page moves, loads, register moves, long branch and call
// Operation
// [RL1] OR immediate into accumulator, zero flag, one cycle
// [RL2] Special register to accumulator, flags kept, one cycle
// [RL3] Accumulator to special register, flags kept, one cycle
// [RL4] Call pushes next address, loads PC, two cycles
// [RL5] Branch loads all PC bits, stack untouched, two cycles
// [RL6] Load immediate into accumulator, flags kept, one cycle
// [RL7] Store accumulator into data register, one cycle
// [RL8] Register move to accumulator or back to register
// [RL9] Register move updates zero flag from value
// [RL10] Zero flag set exactly when result is zero
`timescale 1ns/1ps
module move_branch_or_exec
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Instruction request
  input wire logic instr_valid,
  input wire cmd_t instr_cmd,
  input wire logic [DATA_W-1:0] instr_imm,
  input wire logic [PC_W-1:0] instr_addr,
  input wire logic [REG_AW-1:0] instr_reg,
  input wire logic [SFR_AW-1:0] instr_sfr,
  input wire logic instr_dest,
  output logic instr_ready,
  output logic instr_done,
  // Special-function register page
  output logic sfr_wr_en,
  output logic [SFR_AW-1:0] sfr_addr,
  output logic [DATA_W-1:0] sfr_wr_data,
  input wire logic [DATA_W-1:0] sfr_rd_data,
  // Return stack
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_data,
  // Program counter and flags
  input wire logic pc_advance,
  output logic [PC_W-1:0] pc,
  output logic [DATA_W-1:0] accumulator,
  output logic zero_flag,
  // Data register observation
  input wire logic [REG_AW-1:0] peek_addr,
  output logic [DATA_W-1:0] peek_data
);
  typedef enum logic {ST_IDLE, ST_SECOND} state_t;

  state_t state_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] target_q;
  logic [DATA_W-1:0] acc_q;
  logic zero_q;
  logic done_q;
  logic take;
  logic [DATA_W-1:0] reg_rd;
  logic reg_wr_en;
  logic [REG_AW-1:0] reg_wr_addr;
  logic [DATA_W-1:0] reg_wr_data;
  logic [REG_AW-1:0] reg_rd_addr;

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == ZERO_BYTE;
  endfunction

  function automatic logic is_two_cycle(input cmd_t c);
    return (c == CMD_LONG_CALL) || (c == CMD_LONG_BRANCH);
  endfunction

  // An empty command is taken but never reports completion
  function automatic logic is_one_cycle(input cmd_t c);
    return (c != CMD_NONE) && !is_two_cycle(c);
  endfunction

  function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] v);
    return v + PC_STEP;
  endfunction

  function automatic logic [DATA_W-1:0] or_result(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    return a | b;
  endfunction

  assign instr_ready = (state_q == ST_IDLE);
  assign take = instr_valid && instr_ready;

  // A taken instruction owns the read port; otherwise it serves the peek lookup
  assign reg_rd_addr = take ? instr_reg : peek_addr;

  // Shared data register file; the move uses its read port directly
  data_reg_file u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(reg_wr_en),
    .wr_addr(reg_wr_addr),
    .wr_data(reg_wr_data),
    .rd_addr(reg_rd_addr),
    .rd_data(reg_rd)
  );
  assign peek_data = reg_rd;

  // [RL7] store accumulator write
  // [RL8] register move write back
  always_comb begin
    reg_wr_en = 1'b0;
    reg_wr_addr = instr_reg;
    reg_wr_data = acc_q;
    if (take) begin
      case (instr_cmd)
        CMD_STORE_ACC: begin
          reg_wr_en = 1'b1;
        end
        CMD_REGISTER_MOVE: begin
          reg_wr_en = (instr_dest == DEST_REG);
          reg_wr_data = reg_rd;
        end
        default: begin
          reg_wr_en = 1'b0;
        end
      endcase
    end
  end

  // [RL3] special page write
  assign sfr_wr_en = take && (instr_cmd == CMD_WRITE_SPECIAL);
  assign sfr_addr = instr_sfr;
  assign sfr_wr_data = acc_q;

  // [RL4] push return address
  assign stack_push = take && (instr_cmd == CMD_LONG_CALL);
  // Return address comes from pc before the call lands
  assign stack_push_data = next_pc(pc_q);

  // Two-cycle sequencing for branch and call
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      target_q <= PC_RESET;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && is_two_cycle(instr_cmd)) begin
            state_q <= ST_SECOND;
            target_q <= instr_addr;
          end
        end
        ST_SECOND: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // [RL4] call loads target in second cycle
  // [RL5] branch loads all ten bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= PC_RESET;
    end else if (state_q == ST_SECOND) begin
      pc_q <= target_q;
    end else if (take || pc_advance) begin
      if (!(take && is_two_cycle(instr_cmd))) begin
        pc_q <= next_pc(pc_q);
      end
    end
  end

  // Accumulator updates
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= ACC_RESET;
    end else if (take) begin
      case (instr_cmd)
        // [RL1] OR immediate
        CMD_OR_IMMEDIATE: acc_q <= or_result(acc_q, instr_imm);
        // [RL2] special page read
        CMD_READ_SPECIAL: acc_q <= sfr_rd_data;
        // [RL6] immediate load
        CMD_LOAD_IMMEDIATE: acc_q <= instr_imm;
        // [RL8] move into accumulator
        CMD_REGISTER_MOVE: begin
          if (instr_dest == DEST_ACC) begin
            acc_q <= reg_rd;
          end
        end
        default: acc_q <= acc_q;
      endcase
    end
  end

  // Zero flag, only OR immediate and register move touch it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_q <= 1'b0;
    end else if (take) begin
      case (instr_cmd)
        // [RL10] zero from OR result
        CMD_OR_IMMEDIATE: zero_q <= is_zero(or_result(acc_q, instr_imm));
        // [RL9] zero test of moved value
        CMD_REGISTER_MOVE: zero_q <= is_zero(reg_rd);
        default: zero_q <= zero_q;
      endcase
    end
  end

  // Completion pulse, one cycle after the last cycle of the instruction
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          done_q <= take && is_one_cycle(instr_cmd);
        end
        ST_SECOND: begin
          done_q <= 1'b1;
        end
        default: begin
          done_q <= 1'b0;
        end
      endcase
    end
  end

  assign instr_done = done_q;
  assign pc = pc_q;
  assign accumulator = acc_q;
  assign zero_flag = zero_q;
endmodule

// >>> rtl/exec_pkg.sv
// Constants and types shared by the move, branch and OR execution block
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 10;
  localparam int SFR_AW = 4;
  localparam int REG_AW = 6;
  localparam int REG_DEPTH = 64;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_OR_IMMEDIATE,
    OP_READ_SPECIAL,
    OP_WRITE_SPECIAL,
    OP_LONG_CALL,
    OP_LONG_BRANCH,
    OP_LOAD_IMMEDIATE,
    OP_STORE_ACC
  } op_t;

  // Register move has its own code beyond the 3-bit set above
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_OR_IMMEDIATE,
    CMD_READ_SPECIAL,
    CMD_WRITE_SPECIAL,
    CMD_LONG_CALL,
    CMD_LONG_BRANCH,
    CMD_LOAD_IMMEDIATE,
    CMD_STORE_ACC,
    CMD_REGISTER_MOVE
  } cmd_t;
endpackage

// >>> rtl/data_reg_file.sv
// Sixty-four entry data register file with one write and one read port
`timescale 1ns/1ps
module data_reg_file
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Write port
  input wire logic wr_en,
  input wire logic [REG_AW-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // Read port, combinational
  input wire logic [REG_AW-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem_q [REG_DEPTH];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem_q[i] <= ZERO_BYTE;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_q[rd_addr];
endmodule

// >>> dv/exec_properties.sv
// Checker for the move, branch and OR execution block
`timescale 1ns/1ps
module exec_properties
  import exec_pkg::*;
(
  // Request
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire cmd_t instr_cmd,
  input wire logic [DATA_W-1:0] instr_imm,
  input wire logic [PC_W-1:0] instr_addr,
  input wire logic [SFR_AW-1:0] instr_sfr,
  input wire logic instr_done,
  // Results
  input wire logic sfr_wr_en,
  input wire logic [SFR_AW-1:0] sfr_addr,
  input wire logic [DATA_W-1:0] sfr_wr_data,
  input wire logic [DATA_W-1:0] sfr_rd_data,
  input wire logic stack_push,
  input wire logic [PC_W-1:0] stack_push_data,
  input wire logic [PC_W-1:0] pc,
  input wire logic [DATA_W-1:0] accumulator,
  input wire logic zero_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  cmd_t k;
  assign k = (instr_valid && instr_ready) ? instr_cmd : CMD_NONE;
  or_result_a: assert property (k == CMD_OR_IMMEDIATE |=>
    accumulator == ($past(accumulator) | $past(instr_imm)) && zero_flag == ~|accumulator) else $error("or");
  sfr_read_a: assert property (k == CMD_READ_SPECIAL |=>
    accumulator == $past(sfr_rd_data) && $stable(zero_flag)) else $error("sfr read");
  sfr_write_a: assert property (k == CMD_WRITE_SPECIAL |->
    sfr_wr_en && sfr_wr_data == accumulator ##1 $stable(zero_flag)) else $error("sfr write");
  call_push_a: assert property (k == CMD_LONG_CALL |->
    stack_push && stack_push_data == pc + PC_STEP) else $error("push");
  long_jump_a: assert property (k inside {CMD_LONG_CALL, CMD_LONG_BRANCH} |=>
    !instr_ready ##1 instr_done && pc == $past(instr_addr, 2)) else $error("jump");
  branch_stack_a: assert property (k == CMD_LONG_BRANCH |-> !stack_push) else $error("stack");
  load_imm_a: assert property (k == CMD_LOAD_IMMEDIATE |=>
    accumulator == $past(instr_imm) && $stable(zero_flag) && instr_done) else $error("load");
  push_cause_a: assert property (stack_push |-> k == CMD_LONG_CALL) else $error("stray push");
  sfr_select_a: assert property (k inside {CMD_READ_SPECIAL, CMD_WRITE_SPECIAL} |->
    sfr_addr == instr_sfr) else $error("sfr select");
endmodule

// >>> dv/tb.sv
// Random and corner stimulus for the execution block
`timescale 1ns/1ps
module tb;
  import exec_pkg::*;
  logic clk, sys_rst, instr_valid, instr_dest, pc_advance, instr_ready, instr_done, zero_flag, z;
  cmd_t instr_cmd;
  logic [7:0] instr_imm, sfr_rd_data, accumulator, peek_data, a;
  logic [7:0] m [64];
  logic [9:0] instr_addr, pc, p;
  logic [5:0] instr_reg, peek_addr;
  logic [3:0] instr_sfr;
  logic [15:0] s = 16'hd307;
  cmd_t cc [8] = '{CMD_LOAD_IMMEDIATE, CMD_OR_IMMEDIATE, CMD_OR_IMMEDIATE, CMD_STORE_ACC,
    CMD_REGISTER_MOVE, CMD_LONG_CALL, CMD_LONG_BRANCH, CMD_REGISTER_MOVE};
  logic [15:0] cv [8] = '{16'h0000, 16'h0000, 16'h5000, 16'h3f00, 16'h3f01, 16'h03ff, 16'h0000, 16'h0000};
  int fails, n_tests;
  move_branch_or_exec uut (.clk, .sys_rst, .instr_valid, .instr_cmd, .instr_imm, .instr_addr, .instr_reg,
    .instr_sfr, .instr_dest, .instr_ready, .instr_done, .sfr_wr_en(), .sfr_addr(), .sfr_wr_data(), .sfr_rd_data,
    .stack_push(), .stack_push_data(), .pc_advance, .pc, .accumulator, .zero_flag, .peek_addr, .peek_data);
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string n, input logic [9:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Expected accumulator after one taken command
  function automatic logic [7:0] exp_acc(input cmd_t c, input logic [7:0] acc, imm, sfr, rv, input logic d);
    case (c)
      CMD_OR_IMMEDIATE: return acc | imm;
      CMD_READ_SPECIAL: return sfr;
      CMD_LOAD_IMMEDIATE: return imm;
      CMD_REGISTER_MOVE: return d ? acc : rv;
      default: return acc;
    endcase
  endfunction
  // Operands come packed in v, sfr read data from the generator
  task automatic op(input cmd_t c, input logic [15:0] v);
    {instr_valid, instr_cmd, instr_imm, instr_addr, instr_dest} = {1'b1, c, v[15:8], v[9:0], v[0]};
    {instr_reg, instr_sfr, sfr_rd_data} = {v[13:8], v[3:0], s[7:0]};
    // Fetch advance must be ignored while a command is taken
    pc_advance = v[4];
    if (c == CMD_STORE_ACC) m[v[13:8]] = a;
    if (c == CMD_OR_IMMEDIATE) z = ~|(a | v[15:8]);
    if (c == CMD_REGISTER_MOVE) z = ~|m[v[13:8]];
    a = exp_acc(c, a, v[15:8], s[7:0], m[v[13:8]], v[0]);
    p = c inside {CMD_LONG_CALL, CMD_LONG_BRANCH} ? v[9:0] : p + 10'h001;
    @(posedge clk);
    #1;
    // Request stays up through the refused second cycle
    if (c inside {CMD_LONG_CALL, CMD_LONG_BRANCH}) begin
      chk("ready", instr_ready, 10'h000);
      @(posedge clk);
      #1;
    end
    chk("done", instr_done, 10'h001);
    chk("pc", pc, p);
    chk("acc", accumulator, a);
    chk("zero", zero_flag, z);
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    sys_rst = 1;
    {instr_valid, instr_dest, pc_advance, instr_imm, instr_addr, instr_reg, instr_sfr, sfr_rd_data} = '0;
    instr_cmd = CMD_NONE;
    peek_addr = '0;
    {a, z, p} = '0;
    foreach (m[j]) m[j] = '0;
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 0;
    chk("rst pc", pc, 10'h000);
    chk("rst acc", accumulator, 10'h000);
    foreach (cc[j]) op(cc[j], cv[j]);
    repeat (400) begin
      s = nx(s);
      op(cmd_t'(4'(s[2:0]) + 4'h1), nx(s));
    end
    instr_valid = 0;
    // Idle fetch stretch: pc steps once per cycle, no completion
    pc_advance = 1;
    repeat (5) @(posedge clk);
    #1;
    p = p + 10'h005;
    chk("advance", pc, p);
    chk("idle done", instr_done, 10'h000);
    pc_advance = 0;
    for (int k = 0; k < 64; k++) begin
      peek_addr = 6'(k);
      #1;
      chk("reg", peek_data, m[k]);
    end
    report_and_stop;
  end
endmodule
bind move_branch_or_exec exec_properties chk_i (.clk, .sys_rst, .instr_valid, .instr_ready, .instr_cmd,
  .instr_imm, .instr_addr, .instr_sfr, .instr_done, .sfr_wr_en, .sfr_addr, .sfr_wr_data, .sfr_rd_data, .stack_push,
  .stack_push_data, .pc, .accumulator, .zero_flag);
